//--- serial_port_config_pkg.sv
// constants shared by the serial port configuration register block
// assumes a single 50 MHz system clock and a serial link sampled by it
package serial_port_config_pkg;

    // register offsets (13-bit serial address space)
    localparam logic [12:0] SERIAL_PORT_CONFIG_ADDR = 13'h0000;
    localparam logic [12:0] READBACK_SELECT_ADDR = 13'h0004;
    localparam logic [12:0] USER_VERSION_TAG_LOW_ADDR = 13'h0005;
    localparam logic [12:0] USER_VERSION_TAG_HIGH_ADDR = 13'h0006;

    // serial_port_config field positions
    localparam int SEPARATE_OUTPUT_ENABLE_BIT = 7;
    localparam int LSB_FIRST_BIT = 6;
    localparam int SOFT_RESET_BIT = 5;
    localparam int MIRROR_MSB = 3;

    // readback_select field position
    localparam int READBACK_ACTIVE_BIT = 0;

    // reset values
    localparam logic [7:0] SERIAL_PORT_CONFIG_RESET = 8'h00;
    localparam logic [7:0] READBACK_SELECT_RESET = 8'h00;
    localparam logic [7:0] USER_VERSION_TAG_LOW_RESET = 8'h00;
    localparam logic [7:0] USER_VERSION_TAG_HIGH_RESET = 8'h00;

    // instruction word layout
    localparam int INSTR_BITS = 16;
    localparam int INSTR_RW_BIT = 15;
    localparam int INSTR_LEN_MSB = 14;
    localparam int INSTR_LEN_LSB = 13;
    localparam int INSTR_ADDR_MSB = 12;
    localparam logic [1:0] LEN_STREAM = 2'h3;

    // serial timing counts
    localparam logic [3:0] INSTR_LAST_BIT = 4'hf;
    localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
    localparam int SYNC_STAGES = 2;

    // serial engine states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_INSTR = 2'b01,
        ST_DATA = 2'b10,
        ST_DONE = 2'b11
    } serial_state_t;

endpackage

//--- pin_sync.sv
// two-flop synchroniser for a group of pin inputs
// assumes the inputs are asynchronous to clk; only the second stage reads the first stage
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async_in,
    input wire logic [WIDTH-1:0] reset_value,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            stage1_q <= reset_value;
            stage2_q <= reset_value;
        end else begin
            stage1_q <= async_in;
            stage2_q <= stage1_q;
        end
    end

    assign sync_out = stage2_q;

endmodule // pin_sync

//--- serial_port_config_regs.sv
// serial control port with its port configuration and version tag registers
// assumes sclk, cs_n, data pins, update and mode pins are asynchronous to clk
// and that sclk is slow enough (>= 4 clk per half period) to be edge sampled
//
// How it works
// - with separate_output_enable clear, reads drive the bidirectional pin and serial_out_pin stays undriven.
// - with separate_output_enable set, reads drive serial_out_pin and the bidirectional pin only receives.
// - with the bit order select clear, words go msb first and the address steps down per byte.
// - with the bit order select set, words go lsb first and the address steps up per byte.
// - in i2c mode the bit order select and output enable bits have no effect and read as zero.
// - writing one to the soft reset bit restores every register default and the bit reads back zero.
// - readback_select bit 0 picks buffer (0) or active (1) contents for serial reads.
// - a 16-bit user version tag lives at 0x005 (low) and 0x006 (high), default zero, with no effect.
`timescale 1ns/1ps
module serial_port_config_regs (
    input wire logic clk,
    input wire logic reset,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdio_i,
    output logic sdio_o,
    output logic sdio_oe,
    output logic serial_out_pin_o,
    output logic serial_out_pin_oe,
    input wire logic update,
    input wire logic i2c_mode,
    output logic [15:0] user_version_tag
);

    typedef struct packed {
        serial_port_config_pkg::serial_state_t state;
        logic [3:0] bit_cnt;
        logic [15:0] instr;
        logic is_read;
        logic [1:0] len;
        logic [1:0] bytes_done;
        logic [12:0] addr;
        logic [7:0] rx;
        logic [7:0] tx;
        logic out_bit;
        logic sclk_prev;
        logic update_prev;
        logic [7:0] port_cfg;
        logic readback_active;
        logic [15:0] tag_buf;
        logic [15:0] tag_act;
    } regs_t;

    regs_t s_q;
    regs_t s_d;

    logic [4:0] pins_sync;
    logic sclk_s;
    logic cs_n_s;
    logic sdio_s;
    logic update_s;
    logic i2c_s;

    pin_sync #(
        .WIDTH(5)
    ) u_pin_sync (
        .clk(clk),
        .reset(reset),
        .async_in({i2c_mode, update, sdio_i, cs_n, sclk}),
        .reset_value(5'h02),
        .sync_out(pins_sync)
    );

    assign sclk_s = pins_sync[0];
    assign cs_n_s = pins_sync[1];
    assign sdio_s = pins_sync[2];
    assign update_s = pins_sync[3];
    assign i2c_s = pins_sync[4];

    logic sclk_rise;
    logic sclk_fall;
    logic lsb_first;
    logic sep_out;
    logic reading;

    // in i2c mode bits 7 and 6 of the port configuration are dead
    assign lsb_first = s_q.port_cfg[serial_port_config_pkg::LSB_FIRST_BIT] & ~i2c_s;
    assign sep_out = s_q.port_cfg[serial_port_config_pkg::SEPARATE_OUTPUT_ENABLE_BIT]
        & ~i2c_s;
    assign sclk_rise = sclk_s & ~s_q.sclk_prev;
    assign sclk_fall = ~sclk_s & s_q.sclk_prev;
    assign reading = ~cs_n_s && s_q.is_read && (s_q.state == serial_pkg_data_state());

    function automatic serial_port_config_pkg::serial_state_t serial_pkg_data_state();
        return serial_port_config_pkg::ST_DATA;
    endfunction

    // readback mux, bank chosen by readback_select
    function automatic logic [7:0] rd_byte(input logic [12:0] a, input regs_t s,
                                           input logic i2c);
        logic [7:0] r;
        logic [15:0] tag;
        r = 8'h00;
        tag = s.readback_active ? s.tag_act : s.tag_buf;
        if (a == serial_port_config_pkg::SERIAL_PORT_CONFIG_ADDR) begin
            r[serial_port_config_pkg::MIRROR_MSB:0] =
                s.port_cfg[serial_port_config_pkg::MIRROR_MSB:0];
            if (!i2c) begin
                r[serial_port_config_pkg::SEPARATE_OUTPUT_ENABLE_BIT] =
                    s.port_cfg[serial_port_config_pkg::SEPARATE_OUTPUT_ENABLE_BIT];
                r[serial_port_config_pkg::LSB_FIRST_BIT] =
                    s.port_cfg[serial_port_config_pkg::LSB_FIRST_BIT];
            end
        end else if (a == serial_port_config_pkg::READBACK_SELECT_ADDR) begin
            r[serial_port_config_pkg::READBACK_ACTIVE_BIT] = s.readback_active;
        end else if (a == serial_port_config_pkg::USER_VERSION_TAG_LOW_ADDR) begin
            r = tag[7:0];
        end else if (a == serial_port_config_pkg::USER_VERSION_TAG_HIGH_ADDR) begin
            r = tag[15:8];
        end
        return r;
    endfunction

    always_comb begin
        logic [15:0] instr_n;
        logic [7:0] rx_n;
        logic [12:0] addr_n;
        logic soft_reset;
        instr_n = s_q.instr;
        rx_n = s_q.rx;
        addr_n = s_q.addr;
        soft_reset = 1'b0;
        s_d = s_q;
        s_d.sclk_prev = sclk_s;
        s_d.update_prev = update_s;

        // update pulse moves buffered tag into the active bank
        if (update_s && !s_q.update_prev) begin
            s_d.tag_act = s_q.tag_buf;
        end

        if (cs_n_s) begin
            s_d.state = serial_port_config_pkg::ST_IDLE;
            s_d.bit_cnt = 4'h0;
            s_d.is_read = 1'b0;
        end else begin
            unique case (s_q.state)
                serial_port_config_pkg::ST_IDLE: begin
                    s_d.state = serial_port_config_pkg::ST_INSTR;
                    s_d.bit_cnt = 4'h0;
                end
                serial_port_config_pkg::ST_INSTR: begin
                    if (sclk_rise) begin
                        if (lsb_first) begin
                            instr_n = {sdio_s, s_q.instr[15:1]};
                        end else begin
                            instr_n = {s_q.instr[14:0], sdio_s};
                        end
                        s_d.instr = instr_n;
                        if (s_q.bit_cnt == serial_port_config_pkg::INSTR_LAST_BIT) begin
                            s_d.bit_cnt = 4'h0;
                            s_d.is_read = instr_n[serial_port_config_pkg::INSTR_RW_BIT];
                            s_d.len = instr_n[serial_port_config_pkg::INSTR_LEN_MSB:
                                              serial_port_config_pkg::INSTR_LEN_LSB];
                            s_d.addr = instr_n[serial_port_config_pkg::INSTR_ADDR_MSB:0];
                            s_d.bytes_done = 2'h0;
                            s_d.tx = rd_byte(instr_n[serial_port_config_pkg::INSTR_ADDR_MSB:0],
                                             s_q, i2c_s);
                            s_d.state = serial_port_config_pkg::ST_DATA;
                        end else begin
                            s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                        end
                    end
                end
                serial_port_config_pkg::ST_DATA: begin
                    // read data moves on falling edges, never on the first of a byte
                    if (sclk_fall && s_q.is_read && s_q.bit_cnt != 4'h0) begin
                        if (lsb_first) begin
                            s_d.tx = {1'b0, s_q.tx[7:1]};
                        end else begin
                            s_d.tx = {s_q.tx[6:0], 1'b0};
                        end
                    end
                    if (sclk_rise) begin
                        if (lsb_first) begin
                            rx_n = {sdio_s, s_q.rx[7:1]};
                        end else begin
                            rx_n = {s_q.rx[6:0], sdio_s};
                        end
                        s_d.rx = rx_n;
                        if (s_q.bit_cnt == serial_port_config_pkg::BYTE_LAST_BIT) begin
                            s_d.bit_cnt = 4'h0;
                            if (!s_q.is_read) begin
                                // write lands at once, except the tag, which lands in its buffer bank
                                if (s_q.addr == serial_port_config_pkg::SERIAL_PORT_CONFIG_ADDR)
                                begin
                                    s_d.port_cfg = {rx_n[7:6], 2'b00, rx_n[3:0]};
                                    soft_reset =
                                        rx_n[serial_port_config_pkg::SOFT_RESET_BIT];
                                end else if (s_q.addr ==
                                             serial_port_config_pkg::READBACK_SELECT_ADDR) begin
                                    s_d.readback_active =
                                        rx_n[serial_port_config_pkg::READBACK_ACTIVE_BIT];
                                end else if (s_q.addr ==
                                             serial_port_config_pkg::USER_VERSION_TAG_LOW_ADDR)
                                begin
                                    s_d.tag_buf[7:0] = rx_n;
                                end else if (s_q.addr ==
                                             serial_port_config_pkg::USER_VERSION_TAG_HIGH_ADDR)
                                begin
                                    s_d.tag_buf[15:8] = rx_n;
                                end
                            end
                            if (lsb_first) begin
                                addr_n = s_q.addr + 13'h0001;
                            end else begin
                                addr_n = s_q.addr - 13'h0001;
                            end
                            s_d.addr = addr_n;
                            if (s_q.len != serial_port_config_pkg::LEN_STREAM
                                && s_q.bytes_done == s_q.len) begin
                                s_d.state = serial_port_config_pkg::ST_DONE;
                            end else begin
                                s_d.bytes_done = s_q.bytes_done + 2'h1;
                            end
                            s_d.tx = rd_byte(addr_n, s_d, i2c_s);
                        end else begin
                            s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                        end
                    end
                end
                serial_port_config_pkg::ST_DONE: begin
                    s_d.state = serial_port_config_pkg::ST_DONE;
                end
            endcase
        end

        // soft reset returns every register to default, bit itself not kept
        if (soft_reset) begin
            s_d.port_cfg = serial_port_config_pkg::SERIAL_PORT_CONFIG_RESET;
            s_d.readback_active = serial_port_config_pkg::READBACK_SELECT_RESET[0];
            s_d.tag_buf = {serial_port_config_pkg::USER_VERSION_TAG_HIGH_RESET,
                           serial_port_config_pkg::USER_VERSION_TAG_LOW_RESET};
            s_d.tag_act = {serial_port_config_pkg::USER_VERSION_TAG_HIGH_RESET,
                           serial_port_config_pkg::USER_VERSION_TAG_LOW_RESET};
        end

        s_d.out_bit = lsb_first ? s_d.tx[0] : s_d.tx[7];
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q.state <= serial_port_config_pkg::ST_IDLE;
            s_q.bit_cnt <= 4'h0;
            s_q.instr <= 16'h0000;
            s_q.is_read <= 1'b0;
            s_q.len <= 2'h0;
            s_q.bytes_done <= 2'h0;
            s_q.addr <= 13'h0000;
            s_q.rx <= 8'h00;
            s_q.tx <= 8'h00;
            s_q.out_bit <= 1'b0;
            s_q.sclk_prev <= 1'b0;
            s_q.update_prev <= 1'b0;
            s_q.port_cfg <= serial_port_config_pkg::SERIAL_PORT_CONFIG_RESET;
            s_q.readback_active <= serial_port_config_pkg::READBACK_SELECT_RESET[0];
            s_q.tag_buf <= {serial_port_config_pkg::USER_VERSION_TAG_HIGH_RESET,
                            serial_port_config_pkg::USER_VERSION_TAG_LOW_RESET};
            s_q.tag_act <= {serial_port_config_pkg::USER_VERSION_TAG_HIGH_RESET,
                            serial_port_config_pkg::USER_VERSION_TAG_LOW_RESET};
        end else begin
            s_q <= s_d;
        end
    end

    // pin steering for read data
    assign sdio_o = s_q.out_bit;
    assign serial_out_pin_o = s_q.out_bit;
    assign sdio_oe = reading & ~sep_out;
    assign serial_out_pin_oe = reading & sep_out;
    assign user_version_tag = s_q.tag_act;

endmodule // serial_port_config_regs

//--- serial_port_config_chk.sv
// assertions on the serial port configuration block pins
// assumes one clk domain, synchronous active high reset
`timescale 1ns/1ps
module serial_port_config_chk (
    input wire logic clk,
    input wire logic reset,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdio_i,
    input wire logic sdio_o,
    input wire logic sdio_oe,
    input wire logic serial_out_pin_o,
    input wire logic serial_out_pin_oe,
    input wire logic update,
    input wire logic i2c_mode,
    input wire logic [15:0] user_version_tag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence frame_gap;
        cs_n [*6];
    endsequence
    sequence no_update;
        !update [*8];
    endsequence
    a_oe_one_side: assert property (!(sdio_oe && serial_out_pin_oe))
        else $error("both data outputs enabled");
    a_idle_pins_quiet: assert property (frame_gap |-> !sdio_oe && !serial_out_pin_oe)
        else $error("output enabled outside a frame");
    a_oe_in_frame: assert property ($rose(sdio_oe || serial_out_pin_oe) |-> !$past(cs_n, 2))
        else $error("output enable rose without chip select");
    a_i2c_no_sdo: assert property (i2c_mode [*4] |-> !serial_out_pin_oe)
        else $error("serial output pin driven in i2c mode");
    a_pins_same_bit: assert property (sdio_oe || serial_out_pin_oe |->
        sdio_o == serial_out_pin_o)
        else $error("data pins disagree");
    a_data_settled: assert property ($rose(sclk) && (sdio_oe || serial_out_pin_oe) |->
        $stable(sdio_o) && $stable(serial_out_pin_o))
        else $error("read data moved as the host sampled it");
    a_tag_hold_still: assert property (no_update |->
        $stable(user_version_tag) || user_version_tag == 16'h0000)
        else $error("active tag changed without update");
    a_tag_from_update: assert property ($changed(user_version_tag) && user_version_tag != 16'h0000
        |-> $past(update, 3) && !$past(update, 4))
        else $error("active tag changed with no recent update");
    a_reset_defaults: assert property ($fell(reset) |->
        user_version_tag == 16'h0000 && !sdio_oe && !serial_out_pin_oe)
        else $error("tag or enables not cleared by reset");
endmodule // serial_port_config_chk
bind serial_port_config_regs serial_port_config_chk chk (.clk(clk), .reset(reset), .sclk(sclk),
    .cs_n(cs_n), .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe(sdio_oe),
    .serial_out_pin_o(serial_out_pin_o), .serial_out_pin_oe(serial_out_pin_oe),
    .update(update), .i2c_mode(i2c_mode), .user_version_tag(user_version_tag));

//--- spi_host_model.sv
// spi host model driving the serial control port, mode 0, 4 clk half period
// assumes callers enter frame just after a falling clk edge
`timescale 1ns/1ps
module spi_host_model (
    input wire logic clk,
    input wire logic sdio_o,
    input wire logic sdio_oe,
    input wire logic sdo_o,
    input wire logic sdo_oe,
    output logic sclk,
    output logic cs_n,
    output logic sdio_line
);
    logic host_drv = 1'b0;
    logic host_bit = 1'b0;
    logic last_sdio = 1'b0;
    logic last_sdo = 1'b0;
    logic sdo_line;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
    end
    // released lines show the inverse of their last level
    assign sdio_line = sdio_oe ? sdio_o : (host_drv ? host_bit : ~last_sdio);
    assign sdo_line = sdo_oe ? sdo_o : ~last_sdo;
    always @(posedge clk) begin
        last_sdio <= sdio_line;
        last_sdo <= sdo_line;
    end
    task automatic frame(input logic [15:0] ins, input logic [31:0] wd, input int n,
                         input logic lsb, input logic sep, output logic [31:0] rd);
        int j;
        int p;
        rd = 32'h0;
        cs_n = 1'b0;
        host_drv = 1'b1;
        repeat (4) @(negedge clk);
        for (int i = 0; i < 16 + 8 * n; i++) begin
            j = i - 16;
            p = (j / 8) * 8 + (lsb ? j % 8 : 7 - j % 8);
            host_drv = !(ins[15] && i >= 16);
            host_bit = (i < 16) ? ins[lsb ? i : 15 - i] : wd[p];
            repeat (4) @(negedge clk);
            sclk = 1'b1;
            if (i >= 16) rd[p] = sep ? sdo_line : sdio_line;
            repeat (4) @(negedge clk);
            sclk = 1'b0;
        end
        repeat (4) @(negedge clk);
        cs_n = 1'b1;
        host_drv = 1'b0;
        repeat (4) @(negedge clk);
    endtask
endmodule // spi_host_model

//--- testbench.sv
// self-checking bench for the serial port configuration block
// assumes spi_host_model and the bound checker are compiled alongside
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic update = 1'b0;
    logic i2c_mode = 1'b0;
    logic sclk, cs_n, sdio_i, sdio_o, sdio_oe, sdo_o, sdo_oe;
    logic [15:0] tag;
    logic [31:0] rd;
    int err_total = 0;
    int num_checks = 0;
    int cycles = 0;
    always #10 clk = ~clk;
    serial_port_config_regs dut (.clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n),
        .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe(sdio_oe), .serial_out_pin_o(sdo_o),
        .serial_out_pin_oe(sdo_oe), .update(update), .i2c_mode(i2c_mode),
        .user_version_tag(tag));
    spi_host_model host (.clk(clk), .sdio_o(sdio_o), .sdio_oe(sdio_oe), .sdo_o(sdo_o),
        .sdo_oe(sdo_oe), .sclk(sclk), .cs_n(cs_n), .sdio_line(sdio_i));
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [12:0] a, input logic [7:0] d, input logic lsb);
        host.frame({1'b0, 2'h0, a}, {24'h0, d}, 1, lsb, 1'b0, rd);
    endtask
    task automatic rdc(input logic [12:0] a, input logic [7:0] e, input logic lsb,
                       input logic sep);
        host.frame({1'b1, 2'h0, a}, 32'h0, 1, lsb, sep, rd);
        check(rd, {24'h0, e});
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            err_total++;
            close_out();
        end
    end
    initial begin
        repeat (5) @(negedge clk);
        reset = 1'b0;
        repeat (4) @(negedge clk);
        rdc(13'h0000, 8'h00, 1'b0, 1'b0);
        rdc(13'h0004, 8'h00, 1'b0, 1'b0);
        rdc(13'h0005, 8'h00, 1'b0, 1'b0);
        rdc(13'h0006, 8'h00, 1'b0, 1'b0);
        check({16'h0, tag}, 32'h0);
        $display("defaults done");
        host.frame({1'b0, 2'h1, 13'h0006}, 32'h0000a53c, 2, 1'b0, 1'b0, rd);
        rdc(13'h0006, 8'h3c, 1'b0, 1'b0);
        rdc(13'h0005, 8'ha5, 1'b0, 1'b0);
        check({16'h0, tag}, 32'h0);
        update = 1'b1;
        repeat (10) @(negedge clk);
        update = 1'b0;
        repeat (10) @(negedge clk);
        check({16'h0, tag}, 32'h00003ca5);
        wr(13'h0005, 8'h11, 1'b0);
        rdc(13'h0005, 8'h11, 1'b0, 1'b0);
        wr(13'h0004, 8'h01, 1'b0);
        rdc(13'h0004, 8'h01, 1'b0, 1'b0);
        rdc(13'h0005, 8'ha5, 1'b0, 1'b0);
        wr(13'h0004, 8'h00, 1'b0);
        wr(13'h0001, 8'hff, 1'b0);
        rdc(13'h0001, 8'h00, 1'b0, 1'b0);
        host.frame({1'b1, 2'h1, 13'h0006}, 32'h0, 2, 1'b0, 1'b0, rd);
        check(rd, 32'h0000113c);
        $display("banks done");
        wr(13'h0000, 8'h81, 1'b0);
        rdc(13'h0006, 8'h3c, 1'b0, 1'b1);
        rdc(13'h0000, 8'h81, 1'b0, 1'b1);
        wr(13'h0000, 8'h00, 1'b0);
        rdc(13'h0006, 8'h3c, 1'b0, 1'b0);
        $display("output pin done");
        wr(13'h0000, 8'h42, 1'b0);
        host.frame({1'b0, 2'h1, 13'h0005}, 32'h00007e5a, 2, 1'b1, 1'b0, rd);
        host.frame({1'b1, 2'h1, 13'h0005}, 32'h0, 2, 1'b1, 1'b0, rd);
        check(rd, 32'h00007e5a);
        rdc(13'h0000, 8'h42, 1'b1, 1'b0);
        wr(13'h0000, 8'h24, 1'b1);
        rdc(13'h0000, 8'h00, 1'b0, 1'b0);
        rdc(13'h0005, 8'h00, 1'b0, 1'b0);
        check({16'h0, tag}, 32'h0);
        $display("bit order and soft reset done");
        i2c_mode = 1'b1;
        repeat (4) @(negedge clk);
        wr(13'h0000, 8'hc3, 1'b0);
        rdc(13'h0000, 8'h03, 1'b0, 1'b0);
        wr(13'h0006, 8'h99, 1'b0);
        rdc(13'h0006, 8'h99, 1'b0, 1'b0);
        host.frame({1'b0, 2'h3, 13'h0006}, 32'h00005a77, 3, 1'b0, 1'b0, rd);
        host.frame({1'b1, 2'h2, 13'h0006}, 32'h0, 3, 1'b0, 1'b0, rd);
        check(rd, 32'h00005a77);
        $display("i2c mode done");
        close_out();
    end
endmodule // testbench
